// [hdl/pkfs_pin_decode.sv]
// Decoder of one 2-bit pin mode field into pad controls.
// Assumes the field comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pkfs_pin_decode (
  // Mode field in, controls out
  pkfs_pin_if.dec p
);
  // Pure decode; the top registers the results
  always_comb begin
    p.periph_sel = (p.mode == pkfs_pkg::PKFS_PERIPH);
    p.out_en     = (p.mode == pkfs_pkg::PKFS_OUT);
    p.pull_up    = (p.mode == pkfs_pkg::PKFS_IN_PU);
  end
endmodule : pkfs_pin_decode
`default_nettype wire

// [hdl/pkfs_pin_if.sv]
// Carrier between the top and one pin decoder.
// Assumes a single clock domain.
`timescale 1ns/100ps
`default_nettype none
interface pkfs_pin_if;
  logic [1:0] mode;
  logic       periph_sel;
  logic       out_en;
  logic       pull_up;
  modport dec (input mode, output periph_sel, output out_en, output pull_up);
  modport top (output mode, input periph_sel, input out_en, input pull_up);
endinterface : pkfs_pin_if
`default_nettype wire

// [hdl/pkfs_pkg.sv]
// Constants and types for the port K pin function select block.
// Assumes a 32-bit Avalon-MM slave port; the select register sits in the low 16 bits.
// What this block does
// - A 16-bit software register, read/write in bits 15:4, selects each pin's function and pull-up.
// - Mode 00 routes pin to peripheral; mode 01 drives pin as port output.
// - Mode 10 makes pin a port input with pull-up off.
// - Mode 11 makes pin a port input with pull-up on.
package pkfs_pkg;

  // Register map, byte addresses
  localparam logic [3:0]  SEL_OFFSET    = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;
  localparam logic [15:0] SEL_RESET     = 16'h0000;
  localparam logic [15:0] SEL_WMASK     = 16'hFFF0;
  localparam int          FIRST_PIN     = 2;
  localparam int          NUM_PINS      = 6;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Pad control values while reset is held: every pin on its peripheral
  localparam logic [5:0]  PAD_PERIPH_RESET = 6'h3F;
  localparam logic [5:0]  PAD_OFF_RESET    = 6'h00;
  localparam logic [11:0] MODE_RESET       = 12'h000;

  // Pin mode encodings
  typedef enum logic [1:0] {
    PKFS_PERIPH  = 2'h0,
    PKFS_OUT     = 2'h1,
    PKFS_IN_NOPU = 2'h2,
    PKFS_IN_PU   = 2'h3
  } pkfs_mode_t;

endpackage : pkfs_pkg

// [hdl/pkfs_top.sv]
// Port K pin function select register with Avalon-MM slave and pad controls.
// Assumes one 200 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pkfs_top (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // Pad controls, bit 0 is pin 2
  output logic      [5:0]  o_periph_sel,
  output logic      [5:0]  o_port_out_en,
  output logic      [5:0]  o_pull_up_en,
  output logic      [11:0] o_mode
);

  logic [15:0] sel_reg;
  logic        ack_reg;
  logic        ack_next;
  logic [5:0]  dec_periph;
  logic [5:0]  dec_out;
  logic [5:0]  dec_pu;
  logic        wr_sel;
  logic        conflict;

  // Bus timing in short:
  //   cycle 0: master raises read or write, waitrequest is high
  //   cycle 1: waitrequest low, read data stand, a write lands at its closing edge
  // One wait cycle per access keeps readdata registered and off the address path.
  // The write lands at the edge where the master sees waitrequest low, so the
  // master and the register agree on the moment the new value exists.
  assign wr_sel = i_write && ack_reg && (i_address == pkfs_pkg::SEL_OFFSET);

  // Second cycle of every access is its answer cycle
  assign ack_next = (i_read || i_write) && !ack_reg;

  // Access acknowledge pulse
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) ack_reg <= 1'b0;
    else ack_reg <= ack_next;
  end

  // Waitrequest from its own flop; always the inverse of the acknowledge
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) o_waitrequest <= 1'b1;
    else o_waitrequest <= !ack_next;
  end

  // Select register; low nibble is never written
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sel_reg <= pkfs_pkg::SEL_RESET;
    end else if (wr_sel) begin
      if (i_byteenable[0]) sel_reg[7:0] <= i_writedata[7:0] & pkfs_pkg::SEL_WMASK[7:0];
      if (i_byteenable[1]) sel_reg[15:8] <= i_writedata[15:8];
    end
  end

  // Pins 3 and 4 in opposite directions; software must avoid it, shown as status only
  assign conflict = (o_mode[3:2] == pkfs_pkg::PKFS_OUT) !=
                    (o_mode[5:4] == pkfs_pkg::PKFS_OUT);

  // Read data, zero for unmapped addresses
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) o_readdata <= pkfs_pkg::UNMAPPED_READ;
    else if (i_read && !ack_reg) begin
      case (i_address)
        pkfs_pkg::SEL_OFFSET:    o_readdata <= {16'h0000, sel_reg};
        pkfs_pkg::STATUS_OFFSET: o_readdata <= {31'h0000_0000, conflict};
        default:                 o_readdata <= pkfs_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // One decoder per pin
  // Field map of the select register, two bits per pin:
  //   bits 15:14 pin 7, bits 13:12 pin 6, bits 11:10 pin 5
  //   bits  9:8  pin 4, bits  7:6  pin 3, bits  5:4  pin 2
  //   bits  3:0  hold no pin and always read zero
  // Decoding is kept in a small module so every pin is handled alike;
  // a change to the encoding then touches one place only.
  genvar g;
  generate
    for (g = 0; g < pkfs_pkg::NUM_PINS; g++) begin : g_pin
      pkfs_pin_if pif ();
      assign pif.mode = sel_reg[2*g+5 -: 2];
      pkfs_pin_decode u_dec (.p(pif));
      assign dec_periph[g] = pif.periph_sel;
      assign dec_out[g]    = pif.out_en;
      assign dec_pu[g]     = pif.pull_up;
    end
  endgenerate

  // Registered pad controls; reset matches all-peripheral mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_periph_sel  <= pkfs_pkg::PAD_PERIPH_RESET;
      o_port_out_en <= pkfs_pkg::PAD_OFF_RESET;
      o_pull_up_en  <= pkfs_pkg::PAD_OFF_RESET;
      o_mode        <= pkfs_pkg::MODE_RESET;
    end else begin
      o_periph_sel  <= dec_periph;
      o_port_out_en <= dec_out;
      o_pull_up_en  <= dec_pu;
      o_mode        <= sel_reg[15:4];
    end
  end

  // Checks
  low_nibble_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sel_reg[3:0] == 4'h0) else $error("low nibble not zero");
  pullup_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ##1 o_pull_up_en[0] == ($past(sel_reg[5:4]) == 2'h3)) else $error("pull-up wrong");
  nopull_in_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (sel_reg[5:4] == 2'h2) |=> !o_pull_up_en[0] && !o_port_out_en[0] && !o_periph_sel[0])
    else $error("input no pull-up wrong");
  out_mode_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (sel_reg[15:14] == 2'h1) |=> o_port_out_en[5] && !o_periph_sel[5])
    else $error("output mode wrong");
  periph_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (sel_reg[9:8] == 2'h0) |=> o_periph_sel[2] && !o_port_out_en[2])
    else $error("peripheral mode wrong");
  write_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_sel && i_byteenable[1] |=> sel_reg[15:8] == $past(i_writedata[15:8]))
    else $error("write lost");
  read_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_read && !ack_reg && i_address == pkfs_pkg::SEL_OFFSET |=>
    ack_reg && o_readdata[15:0] == $past(sel_reg)) else $error("read wrong");
  wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_read || i_write) && !ack_reg |=> !o_waitrequest) else $error("no answer");
  conflict_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ##1 conflict == (o_port_out_en[1] != o_port_out_en[2])) else $error("conflict flag");

  write_c: cover property (@(posedge i_clk_sys) wr_sel);
  pu_c: cover property (@(posedge i_clk_sys) o_pull_up_en[3]);
  out_c: cover property (@(posedge i_clk_sys) o_port_out_en[4]);
  conflict_c: cover property (@(posedge i_clk_sys) conflict);
  read_c: cover property (@(posedge i_clk_sys) i_read && !o_waitrequest);

  // Lane checks: an upper lane left out of a write keeps its old bits; a written low lane takes bits 7:4
  lane_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_sel && !i_byteenable[1] |=> sel_reg[15:8] == $past(sel_reg[15:8]))
    else $error("upper lane changed");
  low_lane_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_sel && i_byteenable[0] |=> sel_reg[7:4] == $past(i_writedata[7:4]))
    else $error("low lane write lost");

  // Writes elsewhere never reach the select register
  other_wr_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_write && (i_address != pkfs_pkg::SEL_OFFSET) |=> sel_reg == $past(sel_reg))
    else $error("stray write landed");

  // Upper half of the bus word is never used
  read_hi_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !o_waitrequest |-> o_readdata[31:16] == 16'h0000)
    else $error("upper read half set");

  // Unmapped reads answer zero
  unmapped_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_read && !ack_reg && (i_address != pkfs_pkg::SEL_OFFSET) &&
    (i_address != pkfs_pkg::STATUS_OFFSET) |=> o_readdata == pkfs_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  // Status read reports the direction clash of pins 3 and 4
  status_rd_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_read && !ack_reg && (i_address == pkfs_pkg::STATUS_OFFSET) |=>
    o_readdata == {31'h0000_0000, $past(conflict)})
    else $error("status read wrong");

  // Mode copy follows the register one cycle late
  mode_copy_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ##1 o_mode == $past(sel_reg[15:4])) else $error("mode copy wrong");

  // Every pin: the three pad controls follow its field one cycle late.
  // Checked for all pins, not a sample, since a slip in the field
  // indexing would only show on the pins it hits.
  for (genvar p = 0; p < pkfs_pkg::NUM_PINS; p++) begin : g_pin_chk
    pin_dec_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      ##1 (o_periph_sel[p] == ($past(sel_reg[2*p+5 -: 2]) == 2'h0)) &&
          (o_port_out_en[p] == ($past(sel_reg[2*p+5 -: 2]) == 2'h1)) &&
          (o_pull_up_en[p] == ($past(sel_reg[2*p+5 -: 2]) == 2'h3)))
      else $error("pin decode wrong");
    pin_excl_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      !(o_periph_sel[p] && o_port_out_en[p]) && !(o_port_out_en[p] && o_pull_up_en[p]))
      else $error("pad controls clash");
  end

endmodule : pkfs_top
`default_nettype wire

// [tb/pkfs_pad_model.sv]
// Pad model standing beyond the pin function controls.
// Assumes the pad controls of the top, one clock.
`timescale 1ns/100ps
`default_nettype none
module pkfs_pad_model (
  input  wire logic       i_clk_sys,
  input  wire logic [5:0] i_out_en,
  input  wire logic [5:0] i_pull_up,
  output logic      [5:0] o_pad
);
  logic [5:0] float_reg = 6'h15;
  // Floating pads wander so a stale level never passes for a pull-up
  always_ff @(posedge i_clk_sys) float_reg <= ~float_reg;
  // Pull-up holds an input high; a driven pin shows low here
  always_comb o_pad = (i_pull_up | float_reg) & ~i_out_en;
endmodule : pkfs_pad_model
`default_nettype wire

// [tb/tb_port_k_pin_function_select.sv]
// Self-checking bench for the pin function select block.
// Assumes the top answers each access with one low waitrequest cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_port_k_pin_function_select;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0;
  logic [3:0] addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0000_0000, q, rdata;
  logic wait_req;
  logic [5:0] psel, oen, pup, pad;
  logic [11:0] mode;
  int num_errors = 0, checks = 0;
  pkfs_top u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
    .o_waitrequest(wait_req), .o_periph_sel(psel), .o_port_out_en(oen),
    .o_pull_up_en(pup), .o_mode(mode));
  pkfs_pad_model u_pad (.i_clk_sys(clk), .i_out_en(oen), .i_pull_up(pup), .o_pad(pad));
  // Clock at 200 MHz
  initial forever #2.5 clk = ~clk;
  task automatic wrap_up();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= d;
    do begin @(posedge clk); n++; end while (wait_req !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
    if (n >= 20) begin num_errors++; wrap_up(); end
  endtask : bus
  // Write a pattern, read it back, then look at pads once settled
  task automatic mode_case(input logic [15:0] v, input logic [5:0] ps, oe, pu);
    bus(1, 4'h0, {16'h0000, v});
    bus(0, 4'h0, 32'h0000_0000);
    chk(q, {16'h0000, v & 16'hFFF0});
    repeat (3) @(posedge clk);
    chk({26'h0, psel}, {26'h0, ps});
    chk({26'h0, oen}, {26'h0, oe});
    chk({26'h0, pup}, {26'h0, pu});
    chk({20'h0, mode}, {20'h0, v[15:4]});
    chk({26'h0, pad & pu}, {26'h0, pu});
    $display("mode case %h done", v);
  endtask : mode_case
  task automatic reset_case();
    chk({26'h0, psel}, 32'h0000_003F);
    chk({20'h0, mode, oen, pup}, 32'h0000_0000);
    bus(0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("reset case done");
  endtask : reset_case
  task automatic unmapped_case();
    bus(1, 4'h8, 32'hFFFF_FFFF);
    bus(0, 4'h8, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_46B0);
    bus(1, 4'h4, 32'hFFFF_FFFF);
    bus(0, 4'h4, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("unmapped case done");
  endtask : unmapped_case
  // Upper lane only: low byte keeps its value, pins 3 and 4 stay inputs
  task automatic lane_case();
    be <= 4'h2;
    bus(1, 4'h0, 32'h0000_9EFF);
    be <= 4'hF;
    bus(0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_9EB0);
    $display("lane case done");
  endtask : lane_case
  // Pins 3 and 4 always share a direction in every pattern used
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_case();
    mode_case(16'h394F, 6'h21, 6'h06, 6'h10);
    mode_case(16'h46B0, 6'h10, 6'h28, 6'h01);
    unmapped_case();
    lane_case();
    wrap_up();
  end
endmodule : tb_port_k_pin_function_select
`default_nettype wire
